// [core/ssc_pkg.sv]
// Shared constants, types and helpers of the setpoint select and standby logic
package ssc_pkg;

    // ------------------------------------------------------------
    // Widths and counts
    // ------------------------------------------------------------
    localparam int SP_W = 16;
    localparam int SEL_W = 3;
    localparam int NUM_SP = 8;
    localparam logic [SEL_W-1:0] SEL_LOCAL = 3'h0;

    // ------------------------------------------------------------
    // Values in 0.1 %FS steps, signed
    // ------------------------------------------------------------
    localparam logic signed [SP_W-1:0] SP_MIN = 16'hFF06;
    localparam logic signed [SP_W-1:0] SP_MAX = 16'h04E2;
    localparam logic signed [SP_W-1:0] SP_RESET = 16'h0000;
    localparam logic signed [SP_W-1:0] RETX_OFF = 16'h0000;

    // ------------------------------------------------------------
    // Control template codes that enable selection (51, 54)
    // ------------------------------------------------------------
    localparam logic [7:0] CONTROL_TEMPLATE_SEL_A = 8'h33;
    localparam logic [7:0] CONTROL_TEMPLATE_SEL_B = 8'h36;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 40;
    localparam int SEL_STABLE_NS = 160;
    localparam int SEL_STABLE_CYC =
        (SEL_STABLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ------------------------------------------------------------
    // Run and standby sequence
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_BOOT = 2'h0,
        ST_RUN = 2'h1,
        ST_STANDBY_INDICATOR = 2'h3,
        ST_RESUME = 2'h2
    } ssc_state_t;

    function automatic logic signed [SP_W-1:0] ssc_clamp(
        input logic signed [SP_W-1:0] v,
        input logic signed [SP_W-1:0] lo,
        input logic signed [SP_W-1:0] hi);
        if (v < lo) begin
            return lo;
        end else if (v > hi) begin
            return hi;
        end
        return v;
    endfunction : ssc_clamp

endpackage : ssc_pkg

// [core/ssc_sync.sv]
// Two-stage synchroniser with a stability filter for the selector contacts
`timescale 1ns/1ps
module ssc_sync
    import ssc_pkg::*;
#(
    parameter int W = SEL_W,
    parameter int STABLE = SEL_STABLE_CYC
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Contacts from pins
    input wire logic [W-1:0] async_in,
    // Filtered code
    output logic [W-1:0] stable_out,
    output logic change
);

    localparam int CW = $clog2(STABLE + 1);
    localparam logic [CW-1:0] CNT_LAST = CW'(STABLE - 1);

    logic [W-1:0] meta_reg;
    logic [W-1:0] sync_reg;
    logic [W-1:0] cand_reg;
    logic [CW-1:0] cnt_reg;

    // ------------------------------------------------------------
    // Synchroniser
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_reg <= '0;
            sync_reg <= '0;
        end else begin
            meta_reg <= async_in;
            sync_reg <= meta_reg;
        end
    end

    // ------------------------------------------------------------
    // Stability filter
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cand_reg <= '0;
            cnt_reg <= '0;
            stable_out <= '0;
            change <= 1'b0;
        end else begin
            change <= 1'b0;
            if (sync_reg != cand_reg) begin
                cand_reg <= sync_reg;
                cnt_reg <= '0;
            end else if (cnt_reg < CNT_LAST) begin
                cnt_reg <= cnt_reg + CW'(1);
            end else if (stable_out != cand_reg) begin
                stable_out <= cand_reg;
                change <= 1'b1;
            end
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_code_settled: assert property (
        $changed(stable_out) |-> $past(sync_reg, 1) == stable_out
            && cnt_reg == CNT_LAST)
        else $error("selector code taken before it settled");

endmodule : ssc_sync

// [core/ssc_top.sv]
// Setpoint selection and standby control for a heating/cooling controller
`timescale 1ns/1ps
// Overview of operation
// - Three selector contacts form a binary code, contact 1 lowest, all off local.
// - Code zero picks the local setpoint, codes one to seven remote ones.
// - Selection by contacts works only with control template 51 or 54.
// - Any remote pick places the controller in remote mode.
// - Setpoints are held within -25.0..125.0 %FS and the limiter, reset 0.0.
// - Standby follows its setting and turns off all outputs but control.
// - The standby lamp is lit throughout standby.
// - In standby heating and cooling outputs carry their standby values.
// - Leaving standby restarts control bumplessly from the heating value.
// - Timers and latches stop in standby and restart from zero or released.
// - On return level-mode contacts act, edge-mode contacts do not.
// - The standby setting is kept in nonvolatile storage over power cycles.
// - Entering standby during auto-tuning cancels it, constants unchanged.
// - Standby blanks the display when the option is 1, else it stays on.
// - Communication and control mode are untouched by standby.
// - Remote operation uses the remote setpoint, auto the local one.
module ssc_top
    import ssc_pkg::*;
#(
    parameter int NUM_ALARM = 4,
    parameter int NUM_DOUT = 4
) (
    // Clock and reset
    input wire logic CLK,
    input wire logic RST_N,
    // Selector contacts
    input wire logic SELECTOR_INPUT_1,
    input wire logic SELECTOR_INPUT_2,
    input wire logic SELECTOR_INPUT_3,
    input wire logic SEL_EDGE_MODE,
    input wire logic [7:0] CONTROL_TEMPLATE,
    // Setpoint storage
    input wire logic SP_WR,
    input wire logic [SEL_W-1:0] SP_WR_IDX,
    input wire logic signed [SP_W-1:0] SP_WR_VAL,
    input wire logic SP_LIM_EN,
    input wire logic signed [SP_W-1:0] SP_LIM_LO,
    input wire logic signed [SP_W-1:0] SP_LIM_HI,
    // Standby setting and its nonvolatile copy
    input wire logic STANDBY_SETTING_WR,
    input wire logic STANDBY_SETTING_VAL,
    input wire logic NV_STANDBY,
    input wire logic STANDBY_DISPLAY_OPTION,
    input wire logic signed [SP_W-1:0] HEATING_STANDBY_VALUE,
    input wire logic signed [SP_W-1:0] COOLING_STANDBY_VALUE,
    // Computed control and other outputs
    input wire logic signed [SP_W-1:0] PID_HEAT,
    input wire logic signed [SP_W-1:0] PID_COOL,
    input wire logic [NUM_ALARM-1:0] ALARM_IN,
    input wire logic [NUM_DOUT-1:0] DOUT_IN,
    input wire logic signed [SP_W-1:0] RETX_IN,
    input wire logic AT_ACTIVE,
    // Setpoint results
    output logic signed [SP_W-1:0] TARGET_SETPOINT,
    output logic REMOTE_MODE,
    // Output stage
    output logic signed [SP_W-1:0] HEAT_OUT,
    output logic signed [SP_W-1:0] COOL_OUT,
    output logic MV_PRESET,
    output logic [NUM_ALARM-1:0] ALARM_OUT,
    output logic [NUM_DOUT-1:0] DOUT_OUT,
    output logic signed [SP_W-1:0] RETX_OUT,
    // Timers, latches, tuning
    output logic TIMER_RUN,
    output logic TIMER_CLEAR,
    output logic LATCH_RUN,
    output logic LATCH_RELEASE,
    output logic AT_CANCEL,
    // Indication and storage
    output logic STANDBY_INDICATOR,
    output logic DISPLAY_ON,
    output logic NV_SAVE,
    output logic NV_SAVE_VAL
);

    ssc_state_t state_reg;
    ssc_state_t state_next;
    logic standby_set_reg;
    logic [SEL_W-1:0] stable_code;
    logic code_change;
    logic [SEL_W-1:0] act_code_reg;
    logic [SEL_W-1:0] eff_code;
    logic sel_en;
    logic signed [SP_W-1:0] sp_mem [NUM_SP];
    logic signed [SP_W-1:0] lim_lo;
    logic signed [SP_W-1:0] lim_hi;
    logic signed [SP_W-1:0] heat_sb;
    logic signed [SP_W-1:0] cool_sb;
    logic in_standby_indicator;

    // ------------------------------------------------------------
    // Selector decode
    // ------------------------------------------------------------
    ssc_sync #(.W(SEL_W), .STABLE(SEL_STABLE_CYC)) ssc_sync_inst (
        .clk(CLK),
        .rst_n(RST_N),
        .async_in({SELECTOR_INPUT_3, SELECTOR_INPUT_2,
            SELECTOR_INPUT_1}),
        .stable_out(stable_code),
        .change(code_change)
    );

    assign in_standby_indicator = (state_reg == ST_STANDBY_INDICATOR);
    assign sel_en = (CONTROL_TEMPLATE == CONTROL_TEMPLATE_SEL_A)
        || (CONTROL_TEMPLATE == CONTROL_TEMPLATE_SEL_B);
    assign eff_code = sel_en ? act_code_reg : SEL_LOCAL;

    // Level mode follows the code; edge mode acts only on a fresh change,
    // and changes that happened in standby are dropped.
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            act_code_reg <= SEL_LOCAL;
        end else if (!in_standby_indicator) begin
            if (!SEL_EDGE_MODE) begin
                act_code_reg <= stable_code;
            end else if (code_change) begin
                act_code_reg <= stable_code;
            end
        end
    end

    // ------------------------------------------------------------
    // Setpoint storage
    // ------------------------------------------------------------
    // Limiter bounds kept inside the full range, so no write escapes it
    assign lim_lo = SP_LIM_EN ? ssc_clamp(SP_LIM_LO, SP_MIN, SP_MAX)
        : SP_MIN;
    assign lim_hi = SP_LIM_EN ? ssc_clamp(SP_LIM_HI, SP_MIN, SP_MAX)
        : SP_MAX;

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            for (int i = 0; i < NUM_SP; i++) begin
                sp_mem[i] <= SP_RESET;
            end
        end else if (SP_WR) begin
            sp_mem[SP_WR_IDX] <= ssc_clamp(SP_WR_VAL, lim_lo, lim_hi);
        end
    end

    // Remote mode is independent of standby
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            TARGET_SETPOINT <= SP_RESET;
            REMOTE_MODE <= 1'b0;
        end else begin
            TARGET_SETPOINT <= sp_mem[eff_code];
            REMOTE_MODE <= (eff_code != SEL_LOCAL);
        end
    end

    // ------------------------------------------------------------
    // Standby setting and sequence
    // ------------------------------------------------------------
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            standby_set_reg <= 1'b0;
            NV_SAVE <= 1'b0;
            NV_SAVE_VAL <= 1'b0;
        end else begin
            NV_SAVE <= 1'b0;
            if (state_reg == ST_BOOT) begin
                standby_set_reg <= NV_STANDBY;
            end else if (STANDBY_SETTING_WR) begin
                standby_set_reg <= STANDBY_SETTING_VAL;
                NV_SAVE <= (STANDBY_SETTING_VAL != standby_set_reg);
                NV_SAVE_VAL <= STANDBY_SETTING_VAL;
            end
        end
    end

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_BOOT: state_next = ST_RUN;
            ST_RUN: begin
                if (standby_set_reg) begin
                    state_next = ST_STANDBY_INDICATOR;
                end
            end
            ST_STANDBY_INDICATOR: begin
                if (!standby_set_reg) begin
                    state_next = ST_RESUME;
                end
            end
            ST_RESUME: state_next = ST_RUN;
            default: state_next = ST_BOOT;
        endcase
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            state_reg <= ST_BOOT;
        end else begin
            state_reg <= state_next;
        end
    end

    // ------------------------------------------------------------
    // Output stage
    // ------------------------------------------------------------
    assign heat_sb = ssc_clamp(HEATING_STANDBY_VALUE, SP_MIN, SP_MAX);
    assign cool_sb = ssc_clamp(COOLING_STANDBY_VALUE, SP_MIN, SP_MAX);

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            HEAT_OUT <= SP_RESET;
            COOL_OUT <= SP_RESET;
            MV_PRESET <= 1'b0;
        end else begin
            MV_PRESET <= (state_reg == ST_RESUME);
            if (in_standby_indicator || state_reg == ST_RESUME) begin
                HEAT_OUT <= heat_sb;
                COOL_OUT <= cool_sb;
            end else begin
                HEAT_OUT <= PID_HEAT;
                COOL_OUT <= PID_COOL;
            end
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            ALARM_OUT <= '0;
            DOUT_OUT <= '0;
            RETX_OUT <= RETX_OFF;
        end else begin
            ALARM_OUT <= in_standby_indicator ? '0 : ALARM_IN;
            DOUT_OUT <= in_standby_indicator ? '0 : DOUT_IN;
            RETX_OUT <= in_standby_indicator ? RETX_OFF : RETX_IN;
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            TIMER_RUN <= 1'b0;
            LATCH_RUN <= 1'b0;
            TIMER_CLEAR <= 1'b0;
            LATCH_RELEASE <= 1'b0;
        end else begin
            TIMER_RUN <= (state_reg == ST_RUN);
            LATCH_RUN <= (state_reg == ST_RUN);
            TIMER_CLEAR <= (state_reg == ST_RESUME);
            LATCH_RELEASE <= (state_reg == ST_RESUME);
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            AT_CANCEL <= 1'b0;
            STANDBY_INDICATOR <= 1'b0;
            DISPLAY_ON <= 1'b1;
        end else begin
            AT_CANCEL <= (state_reg == ST_RUN) && standby_set_reg
                && AT_ACTIVE;
            STANDBY_INDICATOR <= in_standby_indicator;
            DISPLAY_ON <= !(in_standby_indicator && STANDBY_DISPLAY_OPTION);
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);

    sequence s_leave_standby_indicator;
        state_reg == ST_STANDBY_INDICATOR ##1 state_reg == ST_RESUME;
    endsequence

    a_lamp_in_standby_indicator: assert property (
        in_standby_indicator |=> STANDBY_INDICATOR)
        else $error("standby lamp off during standby");
    a_standby_values: assert property (
        in_standby_indicator |=> HEAT_OUT == $past(heat_sb) && COOL_OUT == $past(cool_sb))
        else $error("standby values not driven");
    a_others_off: assert property (
        in_standby_indicator |=> ALARM_OUT == '0 && DOUT_OUT == '0 && RETX_OUT == RETX_OFF)
        else $error("outputs not off in standby");
    a_bumpless_start: assert property (
        s_leave_standby_indicator |=> MV_PRESET && HEAT_OUT == $past(heat_sb))
        else $error("resume not bumpless");
    a_timer_restart: assert property (
        state_reg == ST_RESUME |=> TIMER_CLEAR && LATCH_RELEASE && !TIMER_RUN)
        else $error("timers or latches not restarted");
    a_remote_pick: assert property (
        sel_en && act_code_reg != SEL_LOCAL |=> REMOTE_MODE)
        else $error("remote pick without remote mode");
    a_template_gate: assert property (
        !sel_en |=> !REMOTE_MODE && TARGET_SETPOINT == $past(sp_mem[0]))
        else $error("selection active with wrong template");
    a_sp_range: assert property (
        TARGET_SETPOINT >= SP_MIN && TARGET_SETPOINT <= SP_MAX)
        else $error("setpoint out of range");
    a_tune_cancel: assert property (
        state_reg == ST_RUN && standby_set_reg && AT_ACTIVE |=> AT_CANCEL)
        else $error("auto-tuning not cancelled");
    a_display_blank: assert property (
        in_standby_indicator && STANDBY_DISPLAY_OPTION |=> !DISPLAY_ON)
        else $error("display not blanked");
    a_level_resume: assert property (
        state_reg == ST_RESUME && !SEL_EDGE_MODE
            |=> act_code_reg == $past(stable_code))
        else $error("level input ignored on return");
    a_nv_restore: assert property (
        state_reg == ST_BOOT |=> standby_set_reg == $past(NV_STANDBY))
        else $error("standby setting not restored");

endmodule : ssc_top

// [test/ssc_contacts.sv]
// Model of the three selector contacts, with chatter after every change
`timescale 1ns/1ps
module ssc_contacts (
    // Clock
    input wire logic clk,
    // Code requested by the bench
    input wire logic [2:0] code,
    // Contact pins
    output logic sel_1,
    output logic sel_2,
    output logic sel_3
);
    logic [2:0] last_reg;
    logic [2:0] pins;
    int bounce;

    initial begin
        last_reg = 3'h0;
        pins = 3'h0;
        bounce = 0;
    end

    // Contacts chatter for two cycles before they settle
    always @(posedge clk) begin
        #1;
        if (code !== last_reg) begin
            last_reg = code;
            bounce = 2;
        end
        if (bounce > 0) begin
            pins = ~code;
            bounce--;
        end else begin
            pins = code;
        end
    end

    assign {sel_3, sel_2, sel_1} = pins;
endmodule : ssc_contacts

// [test/ssc_top_bench.sv]
// Self-checking bench of the setpoint select and standby logic
`timescale 1ns/1ps
module ssc_top_bench import ssc_pkg::*; ;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [2:0] code = 3'h0;
    logic s1, s2, s3, edge_m, lim_en, sb_wr, sb_val, nv_sb, sb_opt, at_act;
    logic sp_wr;
    logic [2:0] sp_idx;
    logic [7:0] control_template;
    logic [3:0] alm_i, dout_i, alm_o, dout_o;
    logic signed [SP_W-1:0] sp_val, lim_lo, lim_hi, hsv, csv;
    logic signed [SP_W-1:0] pid_h, pid_c, retx_i, tsp, heat, cool, retx_o;
    logic remote, preset, t_run, t_clr, l_run, l_rel, at_cancel;
    logic lamp, disp, nv_save, nv_val;
    int n_errors = 0;
    int num_checks = 0;
    int cyc = 0;
    int n_cancel = 0;
    int n_save = 0;
    int c0, s0, i;
    logic [7:0] tpl_tab [3] = '{8'h36, 8'h32, 8'h00};
    int code_tab [3] = '{5, 3, 7};

    always #20 clk = ~clk;

    ssc_contacts ssc_contacts_inst (.clk(clk), .code(code), .sel_1(s1),
        .sel_2(s2), .sel_3(s3));

    ssc_top ssc_top_inst (.CLK(clk), .RST_N(rst_n), .SELECTOR_INPUT_1(s1),
        .SELECTOR_INPUT_2(s2), .SELECTOR_INPUT_3(s3), .SEL_EDGE_MODE(edge_m),
        .CONTROL_TEMPLATE(control_template), .SP_WR(sp_wr), .SP_WR_IDX(sp_idx),
        .SP_WR_VAL(sp_val), .SP_LIM_EN(lim_en), .SP_LIM_LO(lim_lo),
        .SP_LIM_HI(lim_hi), .STANDBY_SETTING_WR(sb_wr),
        .STANDBY_SETTING_VAL(sb_val), .NV_STANDBY(nv_sb),
        .STANDBY_DISPLAY_OPTION(sb_opt), .HEATING_STANDBY_VALUE(hsv),
        .COOLING_STANDBY_VALUE(csv), .PID_HEAT(pid_h), .PID_COOL(pid_c),
        .ALARM_IN(alm_i), .DOUT_IN(dout_i), .RETX_IN(retx_i),
        .AT_ACTIVE(at_act), .TARGET_SETPOINT(tsp), .REMOTE_MODE(remote),
        .HEAT_OUT(heat), .COOL_OUT(cool), .MV_PRESET(preset),
        .ALARM_OUT(alm_o), .DOUT_OUT(dout_o), .RETX_OUT(retx_o),
        .TIMER_RUN(t_run), .TIMER_CLEAR(t_clr), .LATCH_RUN(l_run),
        .LATCH_RELEASE(l_rel), .AT_CANCEL(at_cancel),
        .STANDBY_INDICATOR(lamp), .DISPLAY_ON(disp), .NV_SAVE(nv_save),
        .NV_SAVE_VAL(nv_val));

    // ------------------------------------------------------------
    // Pulse counters and hang guard
    // ------------------------------------------------------------
    always @(posedge clk) begin
        if (at_cancel === 1'b1) n_cancel++;
        if (nv_save === 1'b1) n_save++;
        cyc++;
        if (cyc == 5000) begin
            n_errors++;
            test_done();
        end
    end

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask : step

    task automatic chk(input string nm, input logic [15:0] exp,
                       input logic [15:0] got);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task automatic test_done();
        $display("checks %0d mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : test_done

    function automatic logic signed [SP_W-1:0] exp_sp(input int k);
        if (k == 6) return SP_MIN;
        if (k == 7) return SP_MAX;
        return 16'(k * 100 + 10);
    endfunction : exp_sp

    task automatic wr_sp(input int k, input logic signed [SP_W-1:0] v);
        sp_wr = 1'b1;
        sp_idx = 3'(k);
        sp_val = v;
        step(1);
        sp_wr = 1'b0;
        step(1);
    endtask : wr_sp

    task automatic set_sb(input logic v);
        sb_wr = 1'b1;
        sb_val = v;
        step(1);
        sb_wr = 1'b0;
    endtask : set_sb

    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        {edge_m, lim_en, sb_wr, sb_val, nv_sb, sb_opt, at_act, sp_wr} = 8'h00;
        control_template = 8'h33;
        sp_idx = 3'h0;
        {sp_val, lim_lo, lim_hi, hsv, csv, retx_i} = '0;
        pid_h = 16'h02BC;
        pid_c = 16'h0032;
        alm_i = 4'hF;
        dout_i = 4'hA;
        step(10);
        chk("disp_rst", 1, disp);
        chk("lamp_rst", 0, lamp);
        rst_n = 1'b1;
        step(3);
        chk("sp_rst", SP_RESET, tsp);
        $display("test reset done");
        for (i = 0; i < 8; i++) wr_sp(i, exp_sp(i));
        wr_sp(6, 16'hFC18);
        wr_sp(7, 16'h7FFF);
        for (i = 0; i < 8; i++) begin
            code = 3'(i);
            step(12);
            chk("sel_sp", exp_sp(i), tsp);
            chk("sel_remote", (i != 0), remote);
        end
        for (i = 0; i < 3; i++) begin
            control_template = tpl_tab[i];
            code = 3'(code_tab[i]);
            step(12);
            chk("control_template_sp", exp_sp(i == 0 ? 5 : 0), tsp);
            chk("control_template_remote", (i == 0), remote);
        end
        control_template = 8'h33;
        code = 3'h3;
        step(12);
        code = 3'h5;
        step(3);
        code = 3'h3;
        for (i = 0; i < 12; i++) begin
            step(1);
            chk("glitch_sp", exp_sp(3), tsp);
        end
        $display("test selection done");
        lim_en = 1'b1;
        lim_lo = 16'hFF9C;
        lim_hi = 16'h012C;
        code = 3'h0;
        step(12);
        wr_sp(0, 16'h0384);
        step(2);
        chk("limit_sp", lim_hi, tsp);
        lim_en = 1'b0;
        $display("test limiter done");
        code = 3'h2;
        at_act = 1'b1;
        hsv = 16'h022B;
        csv = 16'hFF38;
        retx_i = 16'h012C;
        step(12);
        chk("alarm_run", alm_i, alm_o);
        chk("heat_run", pid_h, heat);
        chk("cool_run", pid_c, cool);
        chk("dout_run", dout_i, dout_o);
        chk("retx_run", retx_i, retx_o);
        c0 = n_cancel;
        s0 = n_save;
        set_sb(1'b1);
        step(4);
        chk("cancel", 16'(c0 + 1), 16'(n_cancel));
        chk("nv_save", 16'(s0 + 1), 16'(n_save));
        chk("nv_val", 1, nv_val);
        chk("lamp_on", 1, lamp);
        chk("heat_sb", hsv, heat);
        chk("cool_sb", csv, cool);
        chk("off_sb", 0, {alm_o, dout_o});
        chk("retx_sb", RETX_OFF, retx_o);
        chk("runs_sb", 0, {t_run, l_run});
        chk("disp_opt0", 1, disp);
        chk("remote_sb", 1, remote);
        code = 3'h4;
        step(12);
        chk("frozen_sp", exp_sp(2), tsp);
        at_act = 1'b0;
        set_sb(1'b0);
        for (i = 0; i < 8 && preset !== 1'b1; i++) step(1);
        chk("preset", 1, preset);
        chk("heat_bumpless", hsv, heat);
        chk("clear_release", 3, {t_clr, l_rel});
        step(1);
        chk("heat_resume", pid_h, heat);
        chk("timer_resume", 3, {t_run, l_run});
        step(12);
        chk("level_sp", exp_sp(4), tsp);
        $display("test standby level done");
        edge_m = 1'b1;
        sb_opt = 1'b1;
        c0 = n_cancel;
        step(12);
        set_sb(1'b1);
        step(4);
        chk("disp_opt1", 0, disp);
        chk("no_cancel", 16'(c0), 16'(n_cancel));
        code = 3'h1;
        step(12);
        set_sb(1'b0);
        step(14);
        chk("edge_sp", exp_sp(4), tsp);
        chk("disp_run", 1, disp);
        $display("test standby edge done");
        nv_sb = 1'b1;
        rst_n = 1'b0;
        step(2);
        rst_n = 1'b1;
        step(5);
        chk("nv_lamp", 1, lamp);
        $display("test nonvolatile done");
        test_done();
    end
endmodule : ssc_top_bench
